// ===== logic/rcs_regs.svh
// register offsets, field positions and timing figures of the clock control block
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH
// register offsets on the multiplexed bus
`define RCS_OFF_CTRL    6'h0B
`define RCS_OFF_FLAGS   6'h0C
`define RCS_OFF_VALID   6'h0D
// clock_control field positions
`define RCS_B_SET       7
`define RCS_B_PER_EN    6
`define RCS_B_ALM_EN    5
`define RCS_B_UPD_EN    4
`define RCS_B_SQ_EN     3
`define RCS_B_BIN       2
`define RCS_B_HR24      1
`define RCS_B_DST       0
// interrupt_flags field positions
`define RCS_F_SUM       7
`define RCS_F_PER       6
`define RCS_F_ALM       5
`define RCS_F_UPD       4
// power_valid_status field position
`define RCS_V_VALID     7
// alarm byte code that matches any value
`define RCS_ALM_ANY     2'h3
// rate select code that disables the tap
`define RCS_RS_OFF      4'h0
// timing figures
`define RCS_CLK_KHZ     10000
`define RCS_TBUC_US     244
`define RCS_TUC_US      248
`define RCS_SEC_CYC     10000000
`endif

// ===== logic/rcs_pkg.sv
// types shared by the clock control block
package rcs_pkg;
  // update sequencer states, one-hot
  typedef enum logic [2:0] {
    RCS_UP_IDLE = 3'h1,
    RCS_UP_WAIT = 3'h2,
    RCS_UP_RUN  = 3'h4
  } rcs_up_state_t;
endpackage

// ===== logic/rcs_top.sv
// control, status and interrupt logic of the real-time clock
`timescale 1ns/1ns
`include "rcs_regs.svh"

// What this block does
// RULE1: update cycle every second while inhibit clear
// RULE2: setting inhibit aborts update, blocks further ones
// RULE3: inhibit bit untouched by reset and hardware
// RULE4: periodic enable gates periodic flag; reset clears
// RULE5: alarm enable gates alarm flag; reset clears
// RULE6: alarm when time equals alarm, 11xxxxxx wildcard
// RULE7: update-end enable cleared by reset or inhibit
// RULE8: square wave at selected rate, else low
// RULE9: binary/BCD bit changed only by software
// RULE10: 24/12-hour bit changed only by software
// RULE11: daylight saving jumps April and October
// RULE12: daylight bit clear disables jumps; never auto-modified
// RULE13: summary flag ORs gated flags; drives irq low
// RULE14: flags clear on read or reset low
// RULE15: periodic flag sets on selected tap edge
// RULE16: alarm flag sets on time match
// RULE17: update-ended flag sets after every update
// RULE18: low four flag bits read zero
// RULE19: valid bit zero while power sense low
// RULE20: valid bit set only by reading it
// RULE21: low seven valid-status bits read zero
// RULE22: host holds strobes low when idle
// RULE23: host writes address, then accesses data
// RULE24: inhibit clears update-in-progress status
// RULE25: time bytes off the bus during update
// RULE26: flag read returns values before clearing
module rcs_top #(
  parameter int SEC_CYC = `RCS_SEC_CYC  // cycles of ref_clk per second
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       address_strobe,     // pin, latches address on fall
  input  wire logic       data_strobe,        // pin, data phase while high
  input  wire logic       read_write,         // pin, high reads
  input  wire logic       chip_sel_n,         // pin, active low select
  input  wire logic [7:0] ad_i,               // multiplexed bus, level in
  output logic      [7:0] ad_o,               // multiplexed bus, level out
  output logic            ad_oe_n,            // low while driving the bus
  input  wire logic       power_sense_pin,    // pin, low means supply lost
  input  wire logic [3:0] rate_select,        // rate select bits from divider register
  input  wire logic [7:0] time_sec,           // time bytes from counters
  input  wire logic [7:0] time_min,
  input  wire logic [7:0] time_hour,
  input  wire logic [7:0] alarm_sec,          // alarm bytes from storage
  input  wire logic [7:0] alarm_min,
  input  wire logic [7:0] alarm_hour,
  output logic            irq_n,              // active low interrupt
  output logic            square_wave_pin,
  output logic            update_tick,        // one-cycle pulse: counters advance
  output logic            update_in_progress, // status to divider register
  output logic            time_bus_off,       // time/alarm bytes disconnected
  output logic            binary_mode_select,
  output logic            hour_24_select,
  output logic            daylight_saving_enable
);
  localparam int BUC_CYC = `RCS_TBUC_US * `RCS_CLK_KHZ / 1000; // wait before update
  localparam int UC_CYC  = `RCS_TUC_US * `RCS_CLK_KHZ / 1000;  // update length

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  rst_sync_q;   // reset release chain
  logic        rst_n;        // released reset used by every other flop with a reset
  logic [12:0] pin_s1_q;     // first stage, read only by second stage
  logic [12:0] pin_s2_q;     // synchronised pins

  // release reset two edges after rstn rises
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // every pin passes two flops before use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 13'h0300;  // idle levels: deselected, power present
      pin_s2_q <= 13'h0300;  // so reset alone never clears the valid bit
    end else begin
      pin_s1_q <= {address_strobe, data_strobe, read_write, chip_sel_n, power_sense_pin, ad_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic       astb_s, dstb_s, rw_s, cs_s, pwr_s;
  logic [7:0] ad_s;
  assign astb_s = pin_s2_q[12];
  assign dstb_s = pin_s2_q[11];
  assign rw_s   = pin_s2_q[10];
  assign cs_s   = ~pin_s2_q[9];
  assign pwr_s  = pin_s2_q[8];
  assign ad_s = pin_s2_q[7:0];

  // ----------------------------------------------------------------
  // bus phase tracking
  // ----------------------------------------------------------------
  logic       astb_d1_q, dstb_d1_q;  // previous strobe levels
  logic [5:0] addr_q, addr_d;        // latched register address
  logic [7:0] wdat_q, wdat_d;        // data seen during the data phase
  logic       astb_fall, dstb_fall, rd_end, wr_end;

  assign astb_fall = astb_d1_q & ~astb_s;
  assign dstb_fall = dstb_d1_q & ~dstb_s;
  // access completes on the falling data strobe
  assign rd_end    = dstb_fall & rw_s & cs_s;
  assign wr_end    = dstb_fall & ~rw_s & cs_s;

  // address taken when address strobe falls, data followed while strobe high
  always_comb begin
    addr_d = addr_q;
    wdat_d = wdat_q;
    if (astb_fall && cs_s) begin
      addr_d = ad_s[5:0];  // RULE23
    end
    if (dstb_s) begin
      wdat_d = ad_s;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      astb_d1_q <= 1'b0;
      dstb_d1_q <= 1'b0;
      addr_q    <= 6'h0;
      wdat_q    <= 8'h0;
    end else begin
      astb_d1_q <= astb_s;
      dstb_d1_q <= dstb_s;
      addr_q    <= addr_d;
      wdat_q    <= wdat_d;
    end
  end

  // ----------------------------------------------------------------
  // clock_control register
  // ----------------------------------------------------------------
  // inhibit, data mode, hour mode and daylight bits carry no reset: only
  // software writes move them, so they power up unknown until first written
  logic set_q, set_d, bin_q, bin_d, h24_q, h24_d, dst_q, dst_d;
  logic per_en_q, per_en_d, alm_en_q, alm_en_d, upd_en_q, upd_en_d, sq_en_q, sq_en_d;
  logic wr_ctrl;
  assign wr_ctrl = wr_end && (addr_q == `RCS_OFF_CTRL);

  always_comb begin
    set_d    = set_q;
    bin_d    = bin_q;
    h24_d    = h24_q;
    dst_d    = dst_q;
    per_en_d = per_en_q;
    alm_en_d = alm_en_q;
    upd_en_d = upd_en_q;
    sq_en_d  = sq_en_q;
    if (wr_ctrl) begin
      set_d    = wdat_q[`RCS_B_SET];   // RULE3
      bin_d    = wdat_q[`RCS_B_BIN];   // RULE9
      h24_d    = wdat_q[`RCS_B_HR24];  // RULE10
      dst_d    = wdat_q[`RCS_B_DST];   // RULE12
      per_en_d = wdat_q[`RCS_B_PER_EN];
      alm_en_d = wdat_q[`RCS_B_ALM_EN];
      sq_en_d  = wdat_q[`RCS_B_SQ_EN];
      // raising the inhibit bit wins over a written update-end enable
      upd_en_d = wdat_q[`RCS_B_UPD_EN] & ~(wdat_q[`RCS_B_SET] & ~set_q);  // RULE7
    end
  end

  // bits untouched by reset
  always_ff @(posedge ref_clk) begin
    set_q <= set_d;  // RULE3
    bin_q <= bin_d;  // RULE9
    h24_q <= h24_d;  // RULE10
    dst_q <= dst_d;  // RULE12
  end

  // enables cleared by reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_en_q <= 1'b0;  // RULE4
      alm_en_q <= 1'b0;  // RULE5
      upd_en_q <= 1'b0;  // RULE7
      sq_en_q  <= 1'b0;  // RULE8
    end else begin
      per_en_q <= per_en_d;
      alm_en_q <= alm_en_d;
      upd_en_q <= upd_en_d;
      sq_en_q  <= sq_en_d;
    end
  end

  // counters apply mode, hour format and the daylight jumps themselves
  assign binary_mode_select     = bin_q;  // RULE9
  assign hour_24_select         = h24_q;  // RULE10
  assign daylight_saving_enable = dst_q;  // RULE11 RULE12

  // ----------------------------------------------------------------
  // periodic tap and square wave
  // ----------------------------------------------------------------
  logic [15:0] div_q, div_d;  // free divider standing in for the tap chain
  logic        tap, tap_d1_q, tap_rise;

  // tap chosen by rate select; code zero gives no tap
  function automatic logic pick_tap(input logic [3:0] rs, input logic [15:0] dv);
    pick_tap = (rs == `RCS_RS_OFF) ? 1'b0 : dv[rs];
  endfunction

  assign div_d    = div_q + 16'h1;
  assign tap      = pick_tap(rate_select, div_q);
  assign tap_rise = tap & ~tap_d1_q;  // RULE15

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q           <= 16'h0;
      tap_d1_q        <= 1'b0;
      square_wave_pin <= 1'b0;
    end else begin
      div_q           <= div_d;
      tap_d1_q        <= tap;
      square_wave_pin <= sq_en_q & tap;  // RULE8
    end
  end

  // ----------------------------------------------------------------
  // update sequencer: one second, wait, then update interval
  // ----------------------------------------------------------------
  rcs_pkg::rcs_up_state_t up_q, up_d;
  logic [23:0] sec_q, sec_d;   // one-second prescaler
  logic [15:0] cyc_q, cyc_d;   // phase length counter
  logic        done;           // last cycle of an update

  always_comb begin
    up_d  = up_q;
    cyc_d = cyc_q + 16'h1;
    done  = 1'b0;
    sec_d = (sec_q == 24'(SEC_CYC - 1)) ? 24'h0 : sec_q + 24'h1;
    case (up_q)
      rcs_pkg::RCS_UP_IDLE: begin
        cyc_d = 16'h0;
        if (sec_q == 24'(SEC_CYC - 1) && !set_q) begin
          up_d = rcs_pkg::RCS_UP_WAIT;  // RULE1
        end
      end
      rcs_pkg::RCS_UP_WAIT: begin
        if (cyc_q == 16'(BUC_CYC - 1)) begin
          up_d  = rcs_pkg::RCS_UP_RUN;
          cyc_d = 16'h0;
        end
      end
      rcs_pkg::RCS_UP_RUN: begin
        if (cyc_q == 16'(UC_CYC - 1)) begin
          up_d = rcs_pkg::RCS_UP_IDLE;
          done = 1'b1;
        end
      end
      default: up_d = rcs_pkg::RCS_UP_IDLE;
    endcase
    if (set_q) begin
      up_d = rcs_pkg::RCS_UP_IDLE;  // RULE2 RULE24
      done = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q  <= rcs_pkg::RCS_UP_IDLE;
      sec_q <= 24'h0;
      cyc_q <= 16'h0;
    end else begin
      up_q  <= up_d;
      sec_q <= sec_d;
      cyc_q <= cyc_d;
    end
  end

  assign update_in_progress = (up_q != rcs_pkg::RCS_UP_IDLE);  // RULE24
  assign time_bus_off       = (up_q == rcs_pkg::RCS_UP_RUN);   // RULE25
  // counters advance at the start of the update interval
  assign update_tick = (up_q == rcs_pkg::RCS_UP_WAIT) && (up_d == rcs_pkg::RCS_UP_RUN);  // RULE1

  // ----------------------------------------------------------------
  // flags, summary and interrupt pin
  // ----------------------------------------------------------------
  logic per_flag_q, per_flag_d, alm_flag_q, alm_flag_d, upd_flag_q, upd_flag_d, irq_sum, alarm_hit, rd_flags;

  // a byte matches when equal or marked don't care
  function automatic logic byte_hit(input logic [7:0] t, input logic [7:0] a);
    byte_hit = (a[7:6] == `RCS_ALM_ANY) || (t == a);
  endfunction

  assign alarm_hit = byte_hit(time_sec, alarm_sec) && byte_hit(time_min, alarm_min)
                   && byte_hit(time_hour, alarm_hour);  // RULE6
  // clearing waits for the end of the read, so the read sees old values
  assign rd_flags = rd_end && (addr_q == `RCS_OFF_FLAGS);  // RULE26

  // set wins over a read clear landing in the same cycle
  always_comb begin
    per_flag_d = (per_flag_q & ~rd_flags) | tap_rise;            // RULE14 RULE15
    alm_flag_d = (alm_flag_q & ~rd_flags) | (done & alarm_hit);  // RULE16
    upd_flag_d = (upd_flag_q & ~rd_flags) | done;                // RULE17
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_flag_q <= 1'b0;  // RULE14
      alm_flag_q <= 1'b0;
      upd_flag_q <= 1'b0;
    end else begin
      per_flag_q <= per_flag_d;
      alm_flag_q <= alm_flag_d;
      upd_flag_q <= upd_flag_d;
    end
  end

  assign irq_sum = (per_flag_q & per_en_q) | (alm_flag_q & alm_en_q) | (upd_flag_q & upd_en_q);  // RULE4 RULE5 RULE7 RULE13
  assign irq_n   = ~irq_sum;  // RULE13

  // ----------------------------------------------------------------
  // valid-RAM-and-time bit
  // ----------------------------------------------------------------
  // no reset: it follows only the power sense pin and reads of its register
  logic valid_q, valid_d;
  always_comb begin
    valid_d = valid_q;
    if (rd_end && addr_q == `RCS_OFF_VALID) begin
      valid_d = 1'b1;  // RULE20
    end
    if (!pwr_s) begin
      valid_d = 1'b0;  // RULE19
    end
  end
  always_ff @(posedge ref_clk) begin
    valid_q <= valid_d;  // RULE19
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rdat_d;
  logic       drive;
  always_comb begin
    case (addr_q)
      `RCS_OFF_CTRL:  rdat_d = {set_q, per_en_q, alm_en_q, upd_en_q, sq_en_q, bin_q, h24_q, dst_q};
      `RCS_OFF_FLAGS: rdat_d = {irq_sum, per_flag_q, alm_flag_q, upd_flag_q, 4'h0};  // RULE18
      `RCS_OFF_VALID: rdat_d = {valid_q, 7'h0};                                       // RULE21
      default:        rdat_d = 8'h0;
    endcase
  end
  // only the three mapped registers drive the bus
  assign drive = dstb_s & rw_s & cs_s & ((addr_q == `RCS_OFF_CTRL) || (addr_q == `RCS_OFF_FLAGS)
               || (addr_q == `RCS_OFF_VALID));
  assign ad_oe_n = ~drive;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_o <= 8'h0;
    end else begin
      ad_o <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  irq_summary_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE13
    irq_n == !((per_flag_q && per_en_q) || (alm_flag_q && alm_en_q) || (upd_flag_q && upd_en_q)))
    else $error("interrupt pin disagrees with gated flags");
  update_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE17
    done |=> upd_flag_q) else $error("update-ended flag not set after update");
  inhibit_blocks_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE2
    set_q |=> !update_in_progress) else $error("update ran while inhibited");
  upd_en_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE7
    $rose(set_q) |-> !upd_en_q) else $error("update-end enable survived inhibit");
  flag_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE14
    rd_flags && !tap_rise |=> !per_flag_q) else $error("periodic flag not cleared by read");
  period_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE15
    tap_rise |=> per_flag_q) else $error("periodic flag missed tap edge");
  valid_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE19
    !pwr_s |=> !valid_q) else $error("valid bit set while power low");
  update_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE25
    $rose(time_bus_off) && !set_q |-> time_bus_off [*8]) else $error("update interval too short");
  square_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)  // RULE8
    !sq_en_q |=> !square_wave_pin) else $error("square wave active while disabled");
endmodule

// ===== sim/rcs_host.sv
// bus host model: drives the multiplexed address/data strobes of the clock block
`timescale 1ns/1ns

module rcs_host (
  input  wire logic       ref_clk,
  input  wire logic       slow,           // stretches the gap between phases
  output logic            address_strobe,
  output logic            data_strobe,
  output logic            read_write,
  output logic            chip_sel_n,
  output logic      [7:0] ad_h,           // host side of the bus
  input  wire logic [7:0] ad_o,
  input  wire logic       ad_oe_n
);
  // --------------------------------------------------------------
  // idle state
  // --------------------------------------------------------------
  // strobes rest low between accesses
  initial begin
    address_strobe = 1'b0;
    data_strobe    = 1'b0;
    read_write     = 1'b1;
    chip_sel_n     = 1'b1;
    ad_h           = 8'h00;
  end

  // --------------------------------------------------------------
  // one access
  // --------------------------------------------------------------
  // address phase first, then data phase; each strobe level held
  // several clocks so the pin synchronisers see it
  task automatic xfer(input logic [7:0] addr, input logic rd, input logic [7:0] wdat,
                      output logic [7:0] rdat, output logic drove);
    drove = 1'b0;
    @(posedge ref_clk);
    chip_sel_n     <= 1'b0;
    address_strobe <= 1'b1;
    ad_h           <= addr;
    repeat (4) @(posedge ref_clk);
    address_strobe <= 1'b0;
    repeat (slow ? 12 : 5) @(posedge ref_clk);
    // released bus carries the inverted address on reads, never the old address
    ad_h        <= rd ? ~addr : wdat;
    read_write  <= rd;
    data_strobe <= 1'b1;
    // look at the answer away from the edge so nothing races
    repeat (10) begin
      @(negedge ref_clk);
      if (ad_oe_n === 1'b0) begin
        drove = 1'b1;
      end
    end
    rdat = ad_o;
    @(posedge ref_clk);
    data_strobe <= 1'b0;
    repeat (slow ? 12 : 5) @(posedge ref_clk);
    chip_sel_n <= 1'b1;
    read_write <= 1'b1;
    ad_h       <= ~ad_h;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// ===== sim/tb_rcs_top.sv
// self-checking bench of the clock control block
`timescale 1ns/1ns
`include "rcs_regs.svh"

module tb_rcs_top;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic       ref_clk, rstn, slow, psense;
  logic       astb_w, dstb_w, rw_w, cs_n_w, oe_n, irq_n, sq_out, tick, upd_busy, tbo, bms, h24, dst;
  logic [7:0] ad_h, ad_o, ad_w, rd_v;
  logic [3:0] rsel;
  logic [7:0] t_s, t_m, t_h, a_s, a_m, a_h;
  int         n_fail, comparisons, hi, lo, cnt, ticks;
  logic       drv;

  // bus level: the block wins while it drives
  assign ad_w = oe_n ? ad_h : ad_o;

  rcs_top #(.SEC_CYC(6000)) i_rcs_top (
    .ref_clk(ref_clk), .rstn(rstn), .address_strobe(astb_w), .data_strobe(dstb_w),
    .read_write(rw_w), .chip_sel_n(cs_n_w), .ad_i(ad_w), .ad_o(ad_o), .ad_oe_n(oe_n),
    .power_sense_pin(psense), .rate_select(rsel), .time_sec(t_s), .time_min(t_m),
    .time_hour(t_h), .alarm_sec(a_s), .alarm_min(a_m), .alarm_hour(a_h), .irq_n(irq_n),
    .square_wave_pin(sq_out), .update_tick(tick), .update_in_progress(upd_busy),
    .time_bus_off(tbo), .binary_mode_select(bms), .hour_24_select(h24),
    .daylight_saving_enable(dst));

  rcs_host i_rcs_host (
    .ref_clk(ref_clk), .slow(slow), .address_strobe(astb_w), .data_strobe(dstb_w),
    .read_write(rw_w), .chip_sel_n(cs_n_w), .ad_h(ad_h), .ad_o(ad_o), .ad_oe_n(oe_n));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // counts update pulses, sampled away from the edge that launches them
  always @(negedge ref_clk) begin
    if (tick === 1'b1) begin
      ticks++;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic       y;
    i_rcs_host.xfer({2'h0, a}, 1'b0, d, x, y);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    i_rcs_host.xfer({2'h0, a}, 1'b1, 8'h00, d, drv);
  endtask

  // waits a whole update interval, counting cycles of bus disconnect
  task automatic wait_upd(output int n);
    int g;
    g = 0;
    n = 0;
    while (tbo !== 1'b1 && g < 9000) begin
      @(negedge ref_clk);
      g++;
    end
    while (tbo === 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic test_done;
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, well beyond four update periods
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    test_done;
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    logic [7:0] vals [3];
    n_fail = 0;
    comparisons = 0;
    rstn = 1'b0;
    slow = 1'b0;
    psense = 1'b1;
    rsel = 4'h0;
    {t_s, t_m, t_h} = {8'h12, 8'h34, 8'h05};
    {a_s, a_m, a_h} = {8'hC0, 8'hC0, 8'hC0};
    vals = '{8'hE6, 8'hD5, 8'h9F};
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    // inhibit on, flags start clear
    wr(`RCS_OFF_CTRL, 8'h80);
    rd(`RCS_OFF_CTRL, rd_v); chk(rd_v, 8'h80);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'h00);
    // control patterns; with inhibit already set, a written update-end enable reads back unchanged
    foreach (vals[i]) begin
      slow <= i[0];
      wr(`RCS_OFF_CTRL, vals[i]);
      rd(`RCS_OFF_CTRL, rd_v); chk(rd_v, vals[i]);
      chk({5'h0, bms, h24, dst}, {5'h0, vals[i][2:0]});
    end
    slow <= 1'b0;
    // periodic flag with its enable off, square wave disabled
    wr(`RCS_OFF_CTRL, 8'h80);
    rsel <= 4'h3;
    hi = 0;
    repeat (40) begin
      @(negedge ref_clk);
      hi += (sq_out === 1'b1);
    end
    @(posedge ref_clk);
    rsel <= 4'h0;
    chk(hi[7:0], 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'h40);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'h00);
    // periodic enable and square wave on
    wr(`RCS_OFF_CTRL, 8'hC8);
    rsel <= 4'h3;
    hi = 0;
    lo = 0;
    repeat (40) begin
      @(negedge ref_clk);
      hi += (sq_out === 1'b1);
      lo += (sq_out === 1'b0);
    end
    @(posedge ref_clk);
    rsel <= 4'h0;
    chk({7'h0, hi > 0 && lo > 0}, 8'h01);
    chk({7'h0, irq_n}, 8'h00);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'hC0);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    // reset in mid-run keeps only the software-owned bits
    wr(`RCS_OFF_CTRL, 8'hEF);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({7'h0, sq_out}, 8'h00);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(`RCS_OFF_CTRL, rd_v); chk(rd_v, 8'h87);
    // valid bit follows power sense and reads
    psense <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(`RCS_OFF_VALID, rd_v); chk(rd_v, 8'h00);
    psense <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(`RCS_OFF_VALID, rd_v);
    rd(`RCS_OFF_VALID, rd_v); chk(rd_v, 8'h80);
    wr(`RCS_OFF_VALID, 8'h00);
    rd(`RCS_OFF_VALID, rd_v); chk(rd_v, 8'h80);
    wr(`RCS_OFF_FLAGS, 8'hFF);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'h00);
    // unmapped place is never driven
    rd(6'h0E, rd_v);
    chk({7'h0, drv}, 8'h00);
    // updates running, alarm wildcards match every second
    wr(`RCS_OFF_CTRL, 8'h30);
    wait_upd(cnt);
    chk(cnt[15:8], 8'h09); chk(cnt[7:0], 8'hB0);
    chk(ticks[7:0], 8'h01);
    chk({7'h0, irq_n}, 8'h00);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'hB0);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'h00);
    // one alarm byte off: update ends without alarm
    a_s <= 8'h01;
    wait_upd(cnt);
    chk(ticks[7:0], 8'h02);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'h90);
    // inhibit written during the wait phase aborts the update
    cnt = 0;
    while (upd_busy !== 1'b1 && cnt < 7000) begin
      @(negedge ref_clk);
      cnt++;
    end
    wr(`RCS_OFF_CTRL, 8'hB0);
    chk({7'h0, upd_busy}, 8'h00);
    rd(`RCS_OFF_CTRL, rd_v); chk(rd_v, 8'hA0);
    repeat (6500) @(posedge ref_clk);
    rd(`RCS_OFF_FLAGS, rd_v); chk(rd_v, 8'h00);
    chk(ticks[7:0], 8'h02);
    test_done;
  end
endmodule
